// ==== inc/cbr_defines.svh ====
// command codes, reset values and bit positions of the chromaticity bank
`ifndef CBR_DEFINES_SVH
`define CBR_DEFINES_SVH

`define CBR_CMD_RED_X     8'h76
`define CBR_CMD_RED_Y     8'h77
`define CBR_CMD_GREEN_X   8'h78
`define CBR_CMD_GREEN_Y   8'h79
`define CBR_CMD_LOW_BITS  8'h7a
`define CBR_CMD_BLUE_X    8'h7b

`define CBR_BLANK_VALUE   8'h00
`define CBR_BIT_LAST      3'h7
`define CBR_SYNC_STAGES   2

`endif

// ==== inc/cbr_pkg.sv ====
// types shared by the chromaticity readback bank
package cbr_pkg;

  // serial command engine states
  typedef enum logic [1:0] {
    CBR_ST_CMD,
    CBR_ST_SEND,
    CBR_ST_SKIP
  } cbr_state_type;

  // coordinate bits as delivered by the one-time programmed store
  typedef struct packed {
    logic [7:0] red_x_hi;
    logic [7:0] red_y_hi;
    logic [7:0] green_x_hi;
    logic [7:0] green_y_hi;
    logic [7:0] blue_x_hi;
    logic [1:0] blue_x_lo;
    logic [1:0] blue_y_lo;
    logic [1:0] acolour_x_lo;
    logic [1:0] acolour_y_lo;
  } cbr_fuse_type;

endpackage

// ==== core/cbr_sync.sv ====
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module cbr_sync #(
  parameter int         WIDTH   = 1,
  parameter logic [0:0] RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  // asynchronous level in, synchronised level out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  // first stage is read by the second stage only
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= {WIDTH{RST_VAL}};
      sync_reg <= {WIDTH{RST_VAL}};
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;

endmodule

// ==== core/cbr_readback_regs.sv ====
// serial read-only chromaticity register bank with command decoder
`timescale 1ns/1ps
`include "cbr_defines.svh"
module cbr_readback_regs
  import cbr_pkg::*;
(
  // clock and reset
  input  wire logic   sys_clk,
  input  wire logic   rst_b,
  // serial command pins
  input  wire logic   spi_csx_b,
  input  wire logic   spi_scl,
  input  wire logic   spi_sdi,
  output logic        spi_sdo,
  output logic        spi_sdo_oe_b,
  // one-time programmed store, same clock domain
  input  wire logic   fuse_burnt,
  input  cbr_fuse_type fuse_data
);

  logic          csx_s;
  logic          scl_s;
  logic          sdi_s;
  logic          scl_rise;
  logic          scl_fall;
  logic          load;
  logic [7:0]    cmd_full;
  logic          rd_hit;
  logic [7:0]    rd_byte;

  cbr_state_type state_reg;
  cbr_state_type state_next;
  logic [2:0]    bit_cnt_reg;
  logic [2:0]    bit_cnt_next;
  logic [7:0]    cmd_reg;
  logic [7:0]    cmd_next;
  logic [7:0]    tx_reg;
  logic [7:0]    tx_next;
  logic          sdo_reg;
  logic          sdo_next;
  logic          oe_b_reg;
  logic          oe_b_next;
  logic          scl_d_reg;
  logic          scl_d_next;
  cbr_fuse_type  shadow_reg;
  cbr_fuse_type  shadow_next;

  // pins pass two flops before any logic; select idles high
  cbr_sync #(
    .WIDTH   (1),
    .RST_VAL (1'b1)
  ) u_sync_csx (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .async_in (spi_csx_b),
    .sync_out (csx_s)
  );

  cbr_sync #(
    .WIDTH   (2),
    .RST_VAL (1'b0)
  ) u_sync_data (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .async_in ({spi_scl, spi_sdi}),
    .sync_out ({scl_s, sdi_s})
  );

  // serial clock edges seen on the synchronised level
  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign cmd_full = {cmd_reg[6:0], sdi_s};
  assign load     = (state_reg == CBR_ST_CMD) & ~csx_s & scl_rise &
                    (bit_cnt_reg == `CBR_BIT_LAST);

  // command decode; no power-state term gates it
  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = `CBR_BLANK_VALUE;
    case (cmd_full)
      `CBR_CMD_RED_X:    rd_byte = shadow_reg.red_x_hi;
      `CBR_CMD_RED_Y:    rd_byte = shadow_reg.red_y_hi;
      `CBR_CMD_GREEN_X:  rd_byte = shadow_reg.green_x_hi;
      `CBR_CMD_GREEN_Y:  rd_byte = shadow_reg.green_y_hi;
      `CBR_CMD_LOW_BITS: rd_byte = {shadow_reg.blue_x_lo,
                                    shadow_reg.blue_y_lo,
                                    shadow_reg.acolour_x_lo,
                                    shadow_reg.acolour_y_lo};
      `CBR_CMD_BLUE_X:   rd_byte = shadow_reg.blue_x_hi;
      default:           rd_hit  = 1'b0;
    endcase
  end

  // shadow follows the store: blank until burnt, never host-written
  always_comb begin
    shadow_next = fuse_burnt ? fuse_data : '0;
  end

  // command byte in on rising edges, answer byte out on falling edges
  always_comb begin
    state_next   = state_reg;
    bit_cnt_next = bit_cnt_reg;
    cmd_next     = cmd_reg;
    tx_next      = tx_reg;
    sdo_next     = sdo_reg;
    oe_b_next    = oe_b_reg;
    scl_d_next   = scl_s;
    if (csx_s) begin
      // deselect aborts any frame and frees the line
      state_next   = CBR_ST_CMD;
      bit_cnt_next = 3'h0;
      oe_b_next    = 1'b1;
    end else begin
      case (state_reg)
        CBR_ST_CMD: begin
          if (scl_rise) begin
            cmd_next     = cmd_full;
            bit_cnt_next = bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == `CBR_BIT_LAST) begin
              bit_cnt_next = 3'h0;
              if (rd_hit) begin
                state_next = CBR_ST_SEND;
                tx_next    = rd_byte;
              end else begin
                // foreign codes belong to other blocks; stay silent
                state_next = CBR_ST_SKIP;
              end
            end
          end
        end
        CBR_ST_SEND: begin
          if (scl_fall) begin
            sdo_next  = tx_reg[7];
            tx_next   = {tx_reg[6:0], 1'b0};
            oe_b_next = 1'b0;
          end
          if (scl_rise) begin
            bit_cnt_next = bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == `CBR_BIT_LAST) begin
              // exactly one parameter byte, then go quiet
              state_next = CBR_ST_SKIP;
            end
          end
        end
        CBR_ST_SKIP: begin
          // hold last bit until the falling edge after its sample
          if (scl_fall) begin
            oe_b_next = 1'b1;
          end
        end
        default: begin
          state_next = CBR_ST_CMD;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg   <= CBR_ST_CMD;
      bit_cnt_reg <= 3'h0;
      cmd_reg     <= 8'h00;
      tx_reg      <= 8'h00;
      sdo_reg     <= 1'b0;
      oe_b_reg    <= 1'b1;
      scl_d_reg   <= 1'b0;
      shadow_reg  <= '0;
    end else begin
      state_reg   <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      cmd_reg     <= cmd_next;
      tx_reg      <= tx_next;
      sdo_reg     <= sdo_next;
      oe_b_reg    <= oe_b_next;
      scl_d_reg   <= scl_d_next;
      shadow_reg  <= shadow_next;
    end
  end

  assign spi_sdo      = sdo_reg;
  assign spi_sdo_oe_b = oe_b_reg;

  // checks on decode, shadow and line drive
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  AST_RED_X: assert property (
    load && cmd_full == `CBR_CMD_RED_X
      |=> tx_reg == $past(shadow_reg.red_x_hi))
    else $error("red x byte not loaded");
  AST_RED_Y: assert property (
    load && cmd_full == `CBR_CMD_RED_Y
      |=> tx_reg == $past(shadow_reg.red_y_hi))
    else $error("red y byte not loaded");
  AST_GREEN_X: assert property (
    load && cmd_full == `CBR_CMD_GREEN_X
      |=> tx_reg == $past(shadow_reg.green_x_hi))
    else $error("green x byte not loaded");
  AST_GREEN_Y: assert property (
    load && cmd_full == `CBR_CMD_GREEN_Y
      |=> tx_reg == $past(shadow_reg.green_y_hi))
    else $error("green y byte not loaded");
  AST_LOW_BITS: assert property (
    load && cmd_full == `CBR_CMD_LOW_BITS
      |=> tx_reg == {$past(shadow_reg.blue_x_lo),
                     $past(shadow_reg.blue_y_lo),
                     $past(shadow_reg.acolour_x_lo),
                     $past(shadow_reg.acolour_y_lo)})
    else $error("low bit byte packed wrongly");
  AST_BLUE_X: assert property (
    load && cmd_full == `CBR_CMD_BLUE_X
      |=> tx_reg == $past(shadow_reg.blue_x_hi))
    else $error("blue x byte not loaded");
  AST_ACCEPT: assert property (
    load && cmd_full >= `CBR_CMD_RED_X && cmd_full <= `CBR_CMD_BLUE_X
      |=> state_reg == CBR_ST_SEND)
    else $error("listed read code not accepted");
  AST_FOREIGN: assert property (
    load && !rd_hit |=> state_reg == CBR_ST_SKIP ##1 oe_b_reg)
    else $error("foreign code answered");
  AST_BLANK: assert property (
    !fuse_burnt ##1 !fuse_burnt |-> shadow_reg == '0)
    else $error("unprogrammed value not zero");
  // the release edge itself still clears the shadow, so it is skipped
  AST_HOLD: assert property (
    fuse_burnt && rst_b |=> shadow_reg == $past(fuse_data))
    else $error("shadow differs from programmed value");
  AST_DRIVE: assert property (
    !oe_b_reg |-> state_reg != CBR_ST_CMD && !csx_s ||
      $past(!csx_s))
    else $error("line driven outside a read");

  COV_READ: cover property (load && rd_hit ##1 state_reg == CBR_ST_SEND);
  COV_FOREIGN: cover property (load && !rd_hit);
  COV_DONE: cover property (state_reg == CBR_ST_SEND
                            ##1 state_reg == CBR_ST_SKIP);
  COV_ABORT: cover property (state_reg == CBR_ST_SEND && csx_s);

endmodule

// ==== sim/cbr_host_model.sv ====
// host-side serial master model for the chromaticity bank
`timescale 1ns/1ps
module cbr_host_model (
  // clock
  input  wire logic sys_clk,
  // answer pins from the device
  input  wire logic spi_sdo,
  input  wire logic spi_sdo_oe_b,
  // command pins to the device
  output logic      spi_csx_b,
  output logic      spi_scl,
  output logic      spi_sdi
);
  // half period well above the 3-cycle sampler floor
  localparam int HALF = 6;

  // idle pins: deselected, clock parked low
  initial begin
    spi_csx_b = 1'b1;
    spi_scl   = 1'b0;
    spi_sdi   = 1'b0;
  end

  // one frame: command byte, then exactly one answer byte, msb first
  task automatic read_byte(input  logic [7:0] code,
                           output logic [7:0] data,
                           output logic [3:0] n_drv);
    data  = 8'h00;
    n_drv = 4'h0;
    @(posedge sys_clk);
    spi_csx_b <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      // released data line toggles so stale bits never look valid
      spi_sdi <= (i < 8) ? code[7-i] : ~spi_sdi;
      repeat (HALF) @(posedge sys_clk);
      if (i >= 8) begin
        // a released line shows the inverse, never a stale good bit
        data  = {data[6:0], spi_sdo_oe_b ? ~spi_sdo : spi_sdo};
        n_drv = n_drv + {3'h0, ~spi_sdo_oe_b};
      end
      spi_scl <= 1'b1;
      repeat (HALF) @(posedge sys_clk);
      spi_scl <= 1'b0;
    end
    repeat (HALF) @(posedge sys_clk);
    spi_csx_b <= 1'b1;
    spi_sdi   <= ~spi_sdi;
    repeat (HALF) @(posedge sys_clk);
  endtask

  // frame cut after a few answer clocks; select rises mid-byte
  task automatic cut_frame(input logic [7:0] code,
                           input int         n_bits);
    @(posedge sys_clk);
    spi_csx_b <= 1'b0;
    for (int i = 0; i < 8 + n_bits; i++) begin
      spi_sdi <= (i < 8) ? code[7-i] : ~spi_sdi;
      repeat (HALF) @(posedge sys_clk);
      spi_scl <= 1'b1;
      repeat (HALF) @(posedge sys_clk);
      spi_scl <= 1'b0;
    end
    repeat (2) @(posedge sys_clk);
    spi_csx_b <= 1'b1;
    repeat (HALF) @(posedge sys_clk);
  endtask
endmodule

// ==== sim/cbr_readback_regs_tb.sv ====
// self-checking bench for the chromaticity readback bank
`timescale 1ns/1ps
module cbr_readback_regs_tb
  import cbr_pkg::*;
;
  logic         sys_clk;
  logic         rst_b;
  logic         csx_b;
  logic         scl;
  logic         sdi;
  logic         sdo;
  logic         sdo_oe_b;
  logic         fuse_burnt;
  cbr_fuse_type fuse_data;
  logic [31:0]  lfsr_reg;
  int           n_fail;
  int           n_compared;

  cbr_readback_regs uut (.sys_clk(sys_clk), .rst_b(rst_b),
    .spi_csx_b(csx_b), .spi_scl(scl), .spi_sdi(sdi), .spi_sdo(sdo),
    .spi_sdo_oe_b(sdo_oe_b), .fuse_burnt(fuse_burnt),
    .fuse_data(fuse_data));

  cbr_host_model host (.sys_clk(sys_clk), .spi_sdo(sdo),
    .spi_sdo_oe_b(sdo_oe_b), .spi_csx_b(csx_b), .spi_scl(scl),
    .spi_sdi(sdi));

  // 20 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // expected {driven, byte} for a code; foreign codes are not driven
  function automatic logic [8:0] expect_read(input logic [7:0] c,
      input cbr_fuse_type f, input logic b);
    logic [7:0] v;
    case (c)
      8'h76: v = f.red_x_hi;
      8'h77: v = f.red_y_hi;
      8'h78: v = f.green_x_hi;
      8'h79: v = f.green_y_hi;
      8'h7a: v = {f.blue_x_lo, f.blue_y_lo, f.acolour_x_lo, f.acolour_y_lo};
      8'h7b: v = f.blue_x_hi;
      default: return 9'h000;
    endcase
    return {1'b1, b ? v : 8'h00};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // one frame and its comparisons
  task automatic read_check(input logic [7:0] c);
    logic [7:0] d;
    logic [3:0] n;
    logic [8:0] e;
    e = expect_read(c, fuse_data, fuse_burnt);
    host.read_byte(c, d, n);
    check({4'h0, n}, e[8] ? 8'h08 : 8'h00);
    if (e[8])
      check(d, e[7:0]);
  endtask

  // new store content; shadow follows one cycle later
  task automatic new_fuse(input logic burnt);
    lfsr_reg = lfsr_step(lfsr_reg);
    fuse_data <= cbr_fuse_type'({lfsr_reg, lfsr_reg[15:0] ^ 16'h5a3c});
    fuse_burnt <= burnt;
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic read_all;
    for (int c = 8'h76; c <= 8'h7b; c++)
      read_check(8'(c));
  endtask

  // guard against a hang
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_fail++;
    conclude();
  end

  // main sequence
  initial begin
    rst_b = 1'b0;
    fuse_burnt = 1'b0;
    fuse_data = '0;
    n_fail = 0;
    n_compared = 0;
    lfsr_reg = 32'hc344;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge sys_clk);
    // unprogrammed store reads zero whatever the fuse bus holds
    new_fuse(1'b0);
    read_all();
    // programmed store, read twice: reads leave contents intact
    new_fuse(1'b1);
    read_all();
    read_all();
    // foreign neighbours and extremes are never driven
    read_check(8'h75);
    read_check(8'h7c);
    read_check(8'h00);
    read_check(8'hff);
    // cut frame: deselect frees the line and the next read is whole
    host.cut_frame(8'h78, 3);
    check({7'h0, sdo_oe_b}, 8'h01);
    read_check(8'h78);
    // random codes near the bank and fresh contents
    for (int k = 0; k < 24; k++) begin
      new_fuse(lfsr_reg[3] | lfsr_reg[9]);
      read_check(8'h74 + {5'h0, lfsr_reg[2:0]});
    end
    // reset mid-run: programmed value comes back one cycle after release
    new_fuse(1'b1);
    rst_b <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge sys_clk);
    read_all();
    conclude();
  end
endmodule
